// [hdl/sise_regs.vh]
// Cause code constants and state encodings for the interrupt status encoder
`ifndef SISE_REGS_VH
`define SISE_REGS_VH
// Group nibbles
`define SISE_GRP_RESET 4'h0
`define SISE_GRP_OK 4'h1
`define SISE_GRP_PAUSE 4'h2
`define SISE_GRP_TERM 4'h4
`define SISE_GRP_SVC 4'h8
// Cause codes
`define SISE_C_RST_BASIC 8'h00
`define SISE_C_RST_ADV 8'h01
`define SISE_C_RESEL_OK 8'h10
`define SISE_C_SEL_OK 8'h11
`define SISE_C_CFG_MASTER 8'h12
`define SISE_C_TGT_OK 8'h13
`define SISE_C_TGT_OK_ATN 8'h14
`define SISE_C_CFG_XFER_OK 8'h15
`define SISE_C_SELXFER_OK 8'h16
`define SISE_C_CFG_NONE 8'h17
`define SISE_C_XFER_OK 8'h18
`define SISE_C_MSGIN_PAUSE 8'h20
`define SISE_C_SAVE_PTR 8'h21
`define SISE_C_DISC_ABORT 8'h22
`define SISE_C_TGT_ABORT 8'h23
`define SISE_C_TGT_ABORT_ATN 8'h24
`define SISE_C_PROTO_ABORT 8'h25
`define SISE_C_TAG_MISS 8'h26
`define SISE_C_ID_MISS 8'h27
`define SISE_C_BAD_CMD 8'h40
`define SISE_C_DISCONNECT 8'h41
`define SISE_C_TIMEOUT 8'h42
`define SISE_C_PARITY 8'h43
`define SISE_C_PARITY_ATN 8'h44
`define SISE_C_CFG_NO_CD 8'h45
`define SISE_C_WRONG_ID 8'h46
`define SISE_C_STAT_PARITY 8'h47
`define SISE_C_BAD_PHASE 8'h48
// Reset value of the latched cause
`define SISE_CAUSE_RST 8'h00
// Connection states
`define SISE_ST_DISC 2'h0
`define SISE_ST_TGT 2'h1
`define SISE_ST_INIT 2'h2
`define SISE_ST_CFG 2'h3
// Event numbers (one-hot index into the event vector)
`define SISE_EV_W 5'h1C
`define SISE_E_RST 0
`define SISE_E_RESEL 1
`define SISE_E_SEL 2
`define SISE_E_CFGSEL 3
`define SISE_E_TGTDONE 4
`define SISE_E_SDISC 5
`define SISE_E_CFGXFER 6
`define SISE_E_SELXFER 7
`define SISE_E_XFERDONE 8
`define SISE_E_MSGIN 9
`define SISE_E_SAVEPTR 10
`define SISE_E_DABORT 11
`define SISE_E_TABORT 12
`define SISE_E_ATNABORT 13
`define SISE_E_PROTO 14
`define SISE_E_TAGMISS 15
`define SISE_E_IDMISS 16
`define SISE_E_BADCMD 17
`define SISE_E_DISC 18
`define SISE_E_TMO 19
`define SISE_E_PARITY 20
`define SISE_E_NOCD 21
`define SISE_E_WRONGID 22
`define SISE_E_STPAR 23
`define SISE_E_BADPH 24
`define SISE_E_HWRST 25
`endif

// [hdl/sise_qual.v]
// Qualifier helper: group nibble plus optional phase or ATN qualifier
`timescale 1ns/10ps
`default_nettype none
module sise_qual (
   // Base code and qualifiers
   input wire [7:0] base_i,
   input wire [2:0] phase_i,
   input wire add_phase_i,
   input wire atn_i,
   input wire add_atn_i,
   // Result
   output wire [7:0] code_o
);
   // Phase goes into low three bits, ATN bumps the code by one
   assign code_o = add_phase_i ? {base_i[7:3], phase_i} :
                   (add_atn_i ? (base_i + {7'h00, atn_i}) : base_i);
endmodule
`default_nettype wire

// [hdl/sise_hold.v]
// Hold register: latched cause code that stands until read or reset
`timescale 1ns/10ps
`default_nettype none
`include "sise_regs.vh"
module sise_hold (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Load and release
   input wire load_i,
   input wire [7:0] code_i,
   input wire read_i,
   // Held state
   output reg [7:0] code_o,
   output reg pend_o
);
   // A new cause is taken only when no interrupt is pending or a read comes in the same cycle
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         code_o <= `SISE_CAUSE_RST;
         pend_o <= 1'b0;
      end else if (load_i && (!pend_o || read_i)) begin
         code_o <= code_i;
         pend_o <= 1'b1;
      end else if (read_i) begin
         pend_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [hdl/sise_top.v]
// Interrupt cause encoder: turns core events into an 8-bit cause code
//
// Contract
// - Hard reset or basic Reset command gives 00 and disconnected state
// - From disconnected: Reselect done gives 10 target, Select 11 initiator
// - Config select: 12 into config state if master answered, else 17
// - Target command success gives 13 or 14 by ATN; disconnect-send 13 only
// - Config transfer success gives 15
// - Select-and-transfer success gives 16
// - Initiator transfer done outside message-in gives 18 plus phase
// - Message-in transfer pauses with ACK held, code 20
// - Save-pointer message during select-and-transfer gives 21
// - Aborted Select, Reselect or wait-select while disconnected gives 22
// - Target aborts give 23 with ATN negated, 24 for ATN causes
// - Target protocol breach abort gives 25
// - Tag mismatch on reselection: hold ACK, store tag, code 26
// - Advanced ID or LUN mismatch: hold ACK, expose ID and LUN, 27
// - Unaccepted command code gives 40 from any state
// - Unexpected disconnect 41 then disconnected; timeout 42 disconnected
// - Terminating parity error gives 43 or 44 by ATN
// - C/D negated at config transfer done gives 45, disconnected
// - Non-advanced wrong-ID reselection gives 46, moves to initiator from any state
// - Status byte parity error in select-and-transfer gives 47
// - Unexpected requested phase gives 48 plus phase
// - Upper nibble selects group: reset, success, pause, terminate
// - Phase field is MSG, C/D, I/O; one means asserted
// - Latched code stands until host reads it or reset
`timescale 1ns/10ps
`default_nettype none
`include "sise_regs.vh"
module sise_top (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Mode and bus signals from the core
   input wire adv_mode_i,
   input wire atn_i,
   input wire bus_msg_i,
   input wire bus_cd_i,
   input wire bus_io_i,
   // Completion and error events, one-cycle pulses
   input wire ev_reset_cmd_i,
   input wire ev_resel_done_i,
   input wire ev_sel_done_i,
   input wire ev_cfg_sel_done_i,
   input wire cfg_master_i,
   input wire ev_tgt_done_i,
   input wire ev_send_disc_done_i,
   input wire ev_cfg_xfer_done_i,
   input wire ev_selxfer_done_i,
   input wire ev_xfer_done_i,
   input wire ev_save_ptr_i,
   input wire ev_abort_i,
   input wire ev_ident_err_i,
   input wire ev_atn_halt_i,
   input wire ev_proto_err_i,
   input wire ev_tag_miss_i,
   input wire [7:0] rx_tag_i,
   input wire ev_id_miss_i,
   input wire [2:0] resel_id_i,
   input wire [2:0] resel_lun_i,
   input wire ev_bad_cmd_i,
   input wire ev_disconnect_i,
   input wire ev_timeout_i,
   input wire ev_parity_i,
   input wire ev_status_parity_i,
   input wire ev_bad_phase_i,
   // Host read strobe for the cause code
   input wire host_read_i,
   // Cause code and interrupt
   output reg [7:0] cause_o,
   output reg intrq_o,
   // Connection state
   output reg [1:0] conn_state_o,
   // Held ACK and captured registers
   output reg ack_hold_o,
   output reg [7:0] tag_o,
   output reg [2:0] src_id_o,
   output reg src_id_valid_o,
   output reg [2:0] lun_o
);
   ////////////////////////////////////////////////////////////////////
   // Phase field and event vector
   wire [2:0] bus_phase_field;
   wire msg_in_phase;
   wire in_disc;
   wire in_tgt;
   wire in_init;
   wire [`SISE_EV_W-1:0] ev;
   reg hw_rst_r;
   assign bus_phase_field = {bus_msg_i, bus_cd_i, bus_io_i};
   assign msg_in_phase = (bus_phase_field == 3'h7);
   assign in_disc = (conn_state_o == `SISE_ST_DISC);
   assign in_tgt = (conn_state_o == `SISE_ST_TGT);
   assign in_init = (conn_state_o == `SISE_ST_INIT);

   // First cycle after reset release reports the hard reset
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hw_rst_r <= 1'b1;
      end else begin
         hw_rst_r <= 1'b0;
      end
   end

   // State-gated events, except resets, misses, save-pointer, select-and-transfer, parity, timeout, command and phase errors
   assign ev[`SISE_E_RST] = ev_reset_cmd_i;
   assign ev[`SISE_E_RESEL] = ev_resel_done_i & in_disc;
   assign ev[`SISE_E_SEL] = ev_sel_done_i & in_disc;
   assign ev[`SISE_E_CFGSEL] = ev_cfg_sel_done_i & in_disc;
   assign ev[`SISE_E_TGTDONE] = ev_tgt_done_i & in_tgt;
   assign ev[`SISE_E_SDISC] = ev_send_disc_done_i & in_tgt;
   assign ev[`SISE_E_CFGXFER] = ev_cfg_xfer_done_i &
                               (conn_state_o == `SISE_ST_CFG);
   assign ev[`SISE_E_SELXFER] = ev_selxfer_done_i;
   assign ev[`SISE_E_XFERDONE] = ev_xfer_done_i & in_init & ~msg_in_phase;
   assign ev[`SISE_E_MSGIN] = ev_xfer_done_i & in_init & msg_in_phase;
   assign ev[`SISE_E_SAVEPTR] = ev_save_ptr_i;
   assign ev[`SISE_E_DABORT] = ev_abort_i & in_disc;
   assign ev[`SISE_E_TABORT] = (ev_abort_i | ev_ident_err_i) & in_tgt;
   assign ev[`SISE_E_ATNABORT] = ev_atn_halt_i & in_tgt;
   assign ev[`SISE_E_PROTO] = ev_proto_err_i & in_tgt;
   assign ev[`SISE_E_TAGMISS] = ev_tag_miss_i;
   assign ev[`SISE_E_IDMISS] = ev_id_miss_i & adv_mode_i;
   assign ev[`SISE_E_BADCMD] = ev_bad_cmd_i;
   assign ev[`SISE_E_DISC] = ev_disconnect_i & (in_tgt | in_init);
   assign ev[`SISE_E_TMO] = ev_timeout_i;
   assign ev[`SISE_E_PARITY] = ev_parity_i;
   assign ev[`SISE_E_NOCD] = ev_cfg_xfer_done_i & ~bus_cd_i &
                            (conn_state_o == `SISE_ST_CFG);
   assign ev[`SISE_E_WRONGID] = ev_id_miss_i & ~adv_mode_i;
   assign ev[`SISE_E_STPAR] = ev_status_parity_i;
   assign ev[`SISE_E_BADPH] = ev_bad_phase_i;
   assign ev[`SISE_E_HWRST] = hw_rst_r;
   assign ev[`SISE_EV_W-1:`SISE_E_HWRST+1] = 2'b00;

   ////////////////////////////////////////////////////////////////////
   // Priority encoder: resets first, then terminations, pauses, success
   reg [7:0] base_nxt;
   reg add_phase_nxt;
   reg add_atn_nxt;
   reg hit_nxt;
   reg [1:0] state_nxt;
   always @* begin
      base_nxt = `SISE_CAUSE_RST;
      add_phase_nxt = 1'b0;
      add_atn_nxt = 1'b0;
      hit_nxt = 1'b1;
      state_nxt = conn_state_o;
      if (ev[`SISE_E_HWRST]) begin
         base_nxt = `SISE_C_RST_BASIC;
         state_nxt = `SISE_ST_DISC;
      end else if (ev[`SISE_E_RST]) begin
         base_nxt = adv_mode_i ? `SISE_C_RST_ADV : `SISE_C_RST_BASIC;
         state_nxt = `SISE_ST_DISC;
      end else if (ev[`SISE_E_BADCMD]) begin
         base_nxt = `SISE_C_BAD_CMD;
      end else if (ev[`SISE_E_DISC]) begin
         base_nxt = `SISE_C_DISCONNECT;
         state_nxt = `SISE_ST_DISC;
      end else if (ev[`SISE_E_TMO]) begin
         base_nxt = `SISE_C_TIMEOUT;
         state_nxt = `SISE_ST_DISC;
      end else if (ev[`SISE_E_STPAR]) begin
         base_nxt = `SISE_C_STAT_PARITY;
      end else if (ev[`SISE_E_PARITY]) begin
         base_nxt = `SISE_C_PARITY;
         add_atn_nxt = 1'b1;
      end else if (ev[`SISE_E_NOCD]) begin
         base_nxt = `SISE_C_CFG_NO_CD;
         state_nxt = `SISE_ST_DISC;
      end else if (ev[`SISE_E_WRONGID]) begin
         base_nxt = `SISE_C_WRONG_ID;
         state_nxt = `SISE_ST_INIT;
      end else if (ev[`SISE_E_BADPH]) begin
         base_nxt = `SISE_C_BAD_PHASE;
         add_phase_nxt = 1'b1;
      end else if (ev[`SISE_E_PROTO]) begin
         base_nxt = `SISE_C_PROTO_ABORT;
      end else if (ev[`SISE_E_ATNABORT]) begin
         base_nxt = `SISE_C_TGT_ABORT_ATN;
      end else if (ev[`SISE_E_TABORT]) begin
         base_nxt = `SISE_C_TGT_ABORT;
         add_atn_nxt = 1'b1;
      end else if (ev[`SISE_E_DABORT]) begin
         base_nxt = `SISE_C_DISC_ABORT;
      end else if (ev[`SISE_E_IDMISS]) begin
         base_nxt = `SISE_C_ID_MISS;
         state_nxt = `SISE_ST_INIT;
      end else if (ev[`SISE_E_TAGMISS]) begin
         base_nxt = `SISE_C_TAG_MISS;
         state_nxt = `SISE_ST_INIT;
      end else if (ev[`SISE_E_SAVEPTR]) begin
         base_nxt = `SISE_C_SAVE_PTR;
      end else if (ev[`SISE_E_MSGIN]) begin
         base_nxt = `SISE_C_MSGIN_PAUSE;
      end else if (ev[`SISE_E_XFERDONE]) begin
         base_nxt = `SISE_C_XFER_OK;
         add_phase_nxt = 1'b1;
      end else if (ev[`SISE_E_SELXFER]) begin
         base_nxt = `SISE_C_SELXFER_OK;
      end else if (ev[`SISE_E_CFGXFER]) begin
         base_nxt = `SISE_C_CFG_XFER_OK;
      end else if (ev[`SISE_E_SDISC]) begin
         base_nxt = `SISE_C_TGT_OK;
      end else if (ev[`SISE_E_TGTDONE]) begin
         base_nxt = `SISE_C_TGT_OK;
         add_atn_nxt = 1'b1;
      end else if (ev[`SISE_E_CFGSEL]) begin
         base_nxt = cfg_master_i ? `SISE_C_CFG_MASTER :
                    `SISE_C_CFG_NONE;
         state_nxt = cfg_master_i ? `SISE_ST_CFG : `SISE_ST_DISC;
      end else if (ev[`SISE_E_SEL]) begin
         base_nxt = `SISE_C_SEL_OK;
         state_nxt = `SISE_ST_INIT;
      end else if (ev[`SISE_E_RESEL]) begin
         base_nxt = `SISE_C_RESEL_OK;
         state_nxt = `SISE_ST_TGT;
      end else begin
         hit_nxt = 1'b0;
      end
   end

   // Qualifier merge; group nibble comes from the base code
   wire [7:0] code_w;
   sise_qual u_qual (
      .base_i(base_nxt),
      .phase_i(bus_phase_field),
      .add_phase_i(add_phase_nxt),
      .atn_i(atn_i),
      .add_atn_i(add_atn_nxt),
      .code_o(code_w)
   );

   ////////////////////////////////////////////////////////////////////
   // Hold of the cause; a reset event overrides a pending code
   wire [7:0] held_w;
   wire pend_w;
   wire force_w;
   wire take_w;
   assign force_w = ev[`SISE_E_HWRST] | ev[`SISE_E_RST];
   // Refused events must leave ACK and captures alone as well
   assign take_w = !pend_w || host_read_i || force_w;
   sise_hold u_hold (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .load_i(hit_nxt),
      .code_i(code_w),
      .read_i(host_read_i | force_w),
      .code_o(held_w),
      .pend_o(pend_w)
   );

   // Registered outputs
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cause_o <= `SISE_CAUSE_RST;
         intrq_o <= 1'b0;
      end else begin
         cause_o <= held_w;
         intrq_o <= pend_w & ~host_read_i;
      end
   end

   // Connection state follows each accepted event
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         conn_state_o <= `SISE_ST_DISC;
      end else if (hit_nxt && take_w) begin
         conn_state_o <= state_nxt;
      end
   end

   // Held ACK and captured tag, ID and LUN
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ack_hold_o <= 1'b0;
         tag_o <= 8'h00;
         src_id_o <= 3'h0;
         src_id_valid_o <= 1'b0;
         lun_o <= 3'h0;
      end else begin
         if (take_w && (ev[`SISE_E_MSGIN] || ev[`SISE_E_TAGMISS] ||
             ev[`SISE_E_IDMISS])) begin
            ack_hold_o <= 1'b1;
         end else if (host_read_i || force_w) begin
            ack_hold_o <= 1'b0;
         end
         if (take_w && ev[`SISE_E_TAGMISS]) begin
            tag_o <= rx_tag_i;
         end
         if (take_w && ev[`SISE_E_IDMISS]) begin
            src_id_o <= resel_id_i;
            src_id_valid_o <= 1'b1;
            lun_o <= resel_lun_i;
         end else if (force_w) begin
            src_id_valid_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/sise_properties.sv]
// Checker: cause codes, state moves and hold behaviour at the encoder ports
`timescale 1ns/10ps
`default_nettype none
module sise_chk (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Mode, phase, events and host read
   input wire logic adv_mode_i,
   input wire logic bus_msg_i,
   input wire logic bus_cd_i,
   input wire logic bus_io_i,
   input wire logic ev_reset_cmd_i,
   input wire logic ev_sel_done_i,
   input wire logic ev_xfer_done_i,
   input wire logic ev_bad_cmd_i,
   input wire logic ev_disconnect_i,
   input wire logic ev_timeout_i,
   input wire logic ev_bad_phase_i,
   input wire logic host_read_i,
   // Outputs watched
   input wire logic [7:0] cause_o,
   input wire logic intrq_o,
   input wire logic [1:0] conn_state_o
);
   // One domain, so clock and disable are shared
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////
   // Code and state two edges after the event
   chk_reset_adv: assert property (
      ev_reset_cmd_i && adv_mode_i |-> ##2 cause_o == 8'h01 && intrq_o
      && conn_state_o == 2'h0) else $error("advanced reset code wrong");
   chk_sel_code: assert property (
      ev_sel_done_i && conn_state_o == 2'h0 && !intrq_o |-> ##2
      cause_o == 8'h11 && intrq_o && conn_state_o == 2'h2)
      else $error("select completion code wrong");
   chk_xfer_phase: assert property (
      ev_xfer_done_i && conn_state_o == 2'h2 && !intrq_o
      && !(bus_msg_i && bus_cd_i && bus_io_i) |-> ##2 cause_o == {5'h03,
      $past(bus_msg_i, 2), $past(bus_cd_i, 2), $past(bus_io_i, 2)})
      else $error("transfer done code wrong");
   chk_bad_phase: assert property (
      ev_bad_phase_i && !intrq_o |-> ##2 intrq_o && cause_o == {5'h09,
      $past(bus_msg_i, 2), $past(bus_cd_i, 2), $past(bus_io_i, 2)})
      else $error("unexpected phase code wrong");
   chk_bad_cmd: assert property (
      ev_bad_cmd_i && !intrq_o |-> ##2 cause_o == 8'h40 && intrq_o)
      else $error("invalid command code wrong");
   chk_timeout_code: assert property (
      ev_timeout_i && conn_state_o == 2'h0 && !intrq_o |-> ##2
      cause_o == 8'h42 && conn_state_o == 2'h0) else $error("timeout wrong");
   chk_disc_state: assert property (
      ev_disconnect_i && conn_state_o != 2'h0 && !intrq_o |=> ##1
      cause_o == 8'h41 && conn_state_o == 2'h0)
      else $error("disconnect wrong");
   // Pending code must not move until read
   chk_hold_stable: assert property (
      intrq_o && !host_read_i && !$past(host_read_i)
      && !$past(ev_reset_cmd_i) |=> $stable(cause_o) && intrq_o)
      else $error("pending code changed");
   chk_read_drop: assert property (
      host_read_i && intrq_o |=> !intrq_o) else $error("interrupt stayed up");
   chk_group_legal: assert property (
      intrq_o |-> cause_o[7:4] inside {4'h0, 4'h1, 4'h2, 4'h4})
      else $error("reserved group reported");
endmodule
`default_nettype wire

// [verif/sise_host_model.sv]
// Host model: reads the latched cause after a random delay
`timescale 1ns/10ps
`default_nettype none
module sise_host_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Read permission and pending interrupt
   input wire logic en_i,
   input wire logic irq_i,
   // Read strobe into the encoder
   output logic host_read_o
);
   logic [2:0] wait_r;
   // Delay of 0 to 7 cycles gives prompt and slow hosts; one-cycle strobe,
   // dropped at once so one interrupt is never read twice
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         host_read_o <= 1'b0;
         wait_r <= 3'h0;
      end else if (host_read_o) begin
         host_read_o <= 1'b0;
         wait_r <= 3'($urandom);
      end else if (en_i && irq_i) begin
         if (wait_r == 3'h0)
            host_read_o <= 1'b1;
         else
            wait_r <= wait_r - 3'h1;
      end
   end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Testbench: event stimulus, expected cause codes, refused events
`timescale 1ns/10ps
`default_nettype none
module tb;
   // Design inputs, all set at time zero
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic adv = 1'b0;
   logic atn = 1'b0;
   logic cfgm = 1'b0;
   logic host_en = 1'b0;
   logic [2:0] ph = 3'h0;
   logic [2:0] rid = 3'h0;
   logic [2:0] rlun = 3'h0;
   logic [7:0] rtag = 8'h00;
   logic [21:0] ev = 22'h000000;
   // Design outputs
   logic rd;
   logic irq, ack, sidv;
   logic [7:0] cause, tag;
   logic [2:0] sid, lun;
   logic [1:0] st;
   // Bookkeeping
   logic [1:0] st_now = 2'h0;
   int fails = 0;
   int total_checks = 0;
   int pool [5] = '{7, 9, 16, 20, 21};

   // Clock at 200 MHz
   always #2.5 ref_clk_i = ~ref_clk_i;

   sise_top sise_top_inst (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .adv_mode_i(adv),
      .atn_i(atn), .bus_msg_i(ph[2]), .bus_cd_i(ph[1]), .bus_io_i(ph[0]),
      .ev_reset_cmd_i(ev[0]), .ev_resel_done_i(ev[1]), .ev_sel_done_i(ev[2]),
      .ev_cfg_sel_done_i(ev[3]), .cfg_master_i(cfgm), .ev_tgt_done_i(ev[4]),
      .ev_send_disc_done_i(ev[5]), .ev_cfg_xfer_done_i(ev[6]),
      .ev_selxfer_done_i(ev[7]), .ev_xfer_done_i(ev[8]),
      .ev_save_ptr_i(ev[9]), .ev_abort_i(ev[10]), .ev_ident_err_i(ev[11]),
      .ev_atn_halt_i(ev[12]), .ev_proto_err_i(ev[13]),
      .ev_tag_miss_i(ev[14]), .rx_tag_i(rtag), .ev_id_miss_i(ev[15]),
      .resel_id_i(rid), .resel_lun_i(rlun), .ev_bad_cmd_i(ev[16]),
      .ev_disconnect_i(ev[17]), .ev_timeout_i(ev[18]), .ev_parity_i(ev[19]),
      .ev_status_parity_i(ev[20]), .ev_bad_phase_i(ev[21]),
      .host_read_i(rd), .cause_o(cause), .intrq_o(irq), .conn_state_o(st),
      .ack_hold_o(ack), .tag_o(tag), .src_id_o(sid), .src_id_valid_o(sidv),
      .lun_o(lun));

   sise_host_model sise_host_model_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .en_i(host_en), .irq_i(irq), .host_read_o(rd));

   ////////////////////////////////////////
   // Expected code for an event index, ATN, phase and state
   function automatic logic [7:0] exp_code(input int i, input logic a,
      input logic t, input logic m, input logic [2:0] p, input logic [1:0] s);
      case (i)
         0: return a ? 8'h01 : 8'h00;
         1: return 8'h10;
         2: return 8'h11;
         3: return m ? 8'h12 : 8'h17;
         4: return 8'h13 + {7'h00, t};
         5: return 8'h13;
         6: return p[1] ? 8'h15 : 8'h45;
         7: return 8'h16;
         8: return (p == 3'h7) ? 8'h20 : {5'h03, p};
         9: return 8'h21;
         10, 11: return (s == 2'h0) ? 8'h22 : 8'h23 + {7'h00, t};
         12: return 8'h24;
         13: return 8'h25;
         14: return 8'h26;
         15: return a ? 8'h27 : 8'h46;
         16: return 8'h40;
         17: return 8'h41;
         18: return 8'h42;
         19: return 8'h43 + {7'h00, t};
         20: return 8'h47;
         default: return {5'h09, p};
      endcase
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Bounded wait for the interrupt level; running out ends the run
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      @(negedge ref_clk_i);
      while (irq !== lvl && n < 60) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (irq !== lvl) begin
         check({7'h00, irq}, {7'h00, lvl});
         end_sim();
      end
   endtask

   // One event, its code, a refused event while pending, then the read
   task automatic step(input int i, input logic a, input logic m,
      input logic [3:0] pf, input logic [2:0] sx);
      logic [7:0] e;
      logic [2:0] p;
      logic t;
      logic ack_exp;
      p = pf[3] ? 3'($urandom) : pf[2:0];
      t = 1'($urandom);
      e = exp_code(i, a, t, m, p, st_now);
      ack_exp = i == 14 || (i == 15 && a) || e == 8'h20;
      @(posedge ref_clk_i);
      host_en <= 1'b0;
      adv <= a;
      cfgm <= m;
      ph <= p;
      atn <= t;
      rtag <= 8'($urandom);
      rid <= 3'($urandom);
      rlun <= 3'($urandom);
      ev <= 22'h1 << i;
      @(posedge ref_clk_i);
      ev <= 22'h000000;
      wait_irq(1'b1);
      check(cause, e);
      if (!sx[2]) begin
         check({6'h00, st}, {6'h00, sx[1:0]});
         st_now = sx[1:0];
      end
      check({7'h00, ack}, {7'h00, ack_exp});
      if (i == 14)
         check(tag, rtag);
      if (i == 15 && a)
         check({1'b0, sidv, sid, lun}, {2'b01, rid, rlun});
      // Invalid command while pending must be dropped
      @(posedge ref_clk_i);
      ev <= 22'h1 << 16;
      @(posedge ref_clk_i);
      ev <= 22'h000000;
      repeat (3) @(negedge ref_clk_i);
      check(cause, e);
      @(posedge ref_clk_i);
      host_en <= 1'b1;
      wait_irq(1'b0);
      check({7'h00, ack}, 8'h00);
      $display("test event %0d done", i);
   endtask

   // Reset to disconnected, optional connect, then the event under test
   task automatic trio(input int pre, input int i, input logic a,
      input logic [3:0] pf);
      step(0, 1'b0, 1'b0, 4'h8, 3'h0);
      if (pre != 0)
         step(pre, 1'b0, 1'b0, 4'h8, (pre == 1) ? 3'h1 : 3'h2);
      step(i, a, 1'b0, pf, 3'h4);
   endtask

   ////////////////////////////////////////
   initial begin
      void'($urandom(32'hAE481A69));
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      wait_irq(1'b1);
      check(cause, 8'h00);
      @(posedge ref_clk_i);
      host_en <= 1'b1;
      wait_irq(1'b0);
      step(0, 1'b1, 1'b0, 4'h8, 3'h0);
      step(3, 1'b0, 1'b0, 4'h8, 3'h0);
      step(3, 1'b0, 1'b1, 4'h8, 3'h3);
      step(6, 1'b0, 1'b0, 4'h0, 3'h0);
      step(3, 1'b0, 1'b1, 4'h8, 3'h3);
      step(6, 1'b0, 1'b0, 4'h2, 3'h4);
      trio(1, 4, 1'b0, 4'h8);
      trio(1, 5, 1'b0, 4'h8);
      trio(1, 10, 1'b0, 4'h8);
      trio(1, 11, 1'b0, 4'h8);
      trio(1, 12, 1'b0, 4'h8);
      trio(1, 13, 1'b0, 4'h8);
      trio(1, 19, 1'b0, 4'h8);
      trio(2, 8, 1'b0, 4'h3);
      trio(2, 8, 1'b0, 4'h8);
      trio(2, 8, 1'b0, 4'h7);
      trio(2, 17, 1'b0, 4'h8);
      trio(2, 19, 1'b0, 4'h8);
      trio(2, 21, 1'b0, 4'h8);
      trio(2, 7, 1'b0, 4'h8);
      trio(2, 9, 1'b0, 4'h8);
      trio(2, 20, 1'b0, 4'h8);
      trio(0, 14, 1'b0, 4'h8);
      trio(0, 15, 1'b1, 4'h8);
      trio(0, 15, 1'b0, 4'h8);
      trio(0, 16, 1'b0, 4'h8);
      trio(0, 10, 1'b0, 4'h8);
      trio(0, 18, 1'b0, 4'h8);
      // Random mix of events that need no particular state
      for (int j = 0; j < 6; j++)
         trio($urandom_range(0, 2), pool[$urandom_range(0, 4)],
            1'($urandom), 4'h8);
      // Hard reset over a pending code: outputs clear, then code 00 again
      @(posedge ref_clk_i);
      host_en <= 1'b0;
      ev <= 22'h1 << 16;
      @(posedge ref_clk_i);
      ev <= 22'h000000;
      wait_irq(1'b1);
      check(cause, 8'h40);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(negedge ref_clk_i);
      check({irq, ack, st, 4'h0}, 8'h00);
      check(cause, 8'h00);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      wait_irq(1'b1);
      check(cause, 8'h00);
      check({6'h00, st}, 8'h00);
      @(posedge ref_clk_i);
      host_en <= 1'b1;
      wait_irq(1'b0);
      $display("test mid-run reset done");
      end_sim();
   end
endmodule

bind sise_top sise_chk sise_chk_inst (.ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i), .adv_mode_i(adv_mode_i), .bus_msg_i(bus_msg_i),
   .bus_cd_i(bus_cd_i), .bus_io_i(bus_io_i),
   .ev_reset_cmd_i(ev_reset_cmd_i), .ev_sel_done_i(ev_sel_done_i),
   .ev_xfer_done_i(ev_xfer_done_i), .ev_bad_cmd_i(ev_bad_cmd_i),
   .ev_disconnect_i(ev_disconnect_i), .ev_timeout_i(ev_timeout_i),
   .ev_bad_phase_i(ev_bad_phase_i), .host_read_i(host_read_i),
   .cause_o(cause_o), .intrq_o(intrq_o), .conn_state_o(conn_state_o));
`default_nettype wire
